//--- src/ccsp_top.v
// clock synchronous serial port: avalon slave, shifter, pin control
//
// Function
// - each transfer swaps one 8-bit word
// - internal clock is source over 2(n+1)
// - external clock: clock pin input, undriven
// - writing shift register starts the transfer
// - done interrupt at last sample edge
// - pins work as ports or serial pins
// - bit order select picks lsb or msb
// - polarity picks shift and sample edges
// - external clock: idle data level selectable
// - internal clock stops after eighth pulse
// - internal: hold last bit half period
// - write during hold floats data at once
// - internal clock parks at inverse of polarity bit
`timescale 1ns/1ps
`include "ccsp_regs.vh"

module ccsp_top (
    // clock and reset
    input  wire                    ref_clk_in,
    input  wire                    reset_in,
    // avalon-mm slave
    input  wire [`CCSP_ADDR_W-1:0] avs_address_in,
    input  wire                    avs_read_in,
    input  wire                    avs_write_in,
    input  wire [31:0]             avs_writedata_in,
    output wire [31:0]             avs_readdata_out,
    output wire                    avs_waitrequest_out,
    // interrupt
    output wire                    irq_out,
    // clock pin
    input  wire                    sync_clock_pin_in,
    output wire                    sync_clock_pin_out,
    output wire                    sync_clock_pin_oe_n_out,
    // data pins
    output wire                    sync_data_out_pin_out,
    output wire                    sync_data_out_pin_oe_n_out,
    input  wire                    sync_data_in_pin_in
);

    reg  [6:0]  sync_serial_control_r;
    reg  [7:0]  sync_serial_rate_divisor_r;
    reg  [7:0]  sync_serial_shift_register_r;
    reg         done_r;
    reg         mask_r;
    reg  [3:0]  gpio_r;
    reg         busy_r;
    reg  [2:0]  bit_cnt_r;
    reg         clk_r;
    reg         out_bit_r;
    reg         hold_r;
    reg         fresh_r;
    reg         pin_prev_r;
    reg         rd_ack_r;
    reg  [31:0] readdata_r;
    reg  [31:0] rd_mux;
    reg         clk_pin_mux;
    reg         clk_oe_n_mux;
    reg         data_pin_mux;
    reg         data_oe_n_mux;

    wire        half_tick;
    wire        clock_polarity_select;
    wire        bit_order_select;
    wire        internal_clock_select;
    wire        idle_output_level_select;
    wire        serial_enable;
    wire        idle_lvl;
    wire        lead_int;
    wire        trail_int;
    wire        lead_ext;
    wire        trail_ext;
    wire        lead;
    wire        trail;
    wire        last_bit;
    wire        done_ev;
    wire        shift_wr;
    wire        status_rd;
    wire        next_bit;
    wire        first_bit;
    wire [7:0]  shifted;

    assign clock_polarity_select    = sync_serial_control_r[`CCSP_CTRL_POL];
    assign bit_order_select         = sync_serial_control_r[`CCSP_CTRL_ORDER];
    assign internal_clock_select    = sync_serial_control_r[`CCSP_CTRL_INTCLK];
    assign idle_output_level_select = sync_serial_control_r[`CCSP_CTRL_IDLE];
    assign serial_enable            = sync_serial_control_r[`CCSP_CTRL_SER_EN];

    // clock rests high for polarity 0, low for polarity 1
    assign idle_lvl = ~clock_polarity_select;

    // bus side: writes never wait, reads take one wait state for registered data
    assign avs_waitrequest_out = avs_read_in & ~rd_ack_r;
    assign avs_readdata_out    = readdata_r;
    assign shift_wr  = avs_write_in && (avs_address_in == `CCSP_ADDR_SHIFT);
    assign status_rd = avs_read_in && !rd_ack_r && (avs_address_in == `CCSP_ADDR_STATUS);

    ccsp_rate_gen u_rate_gen (
        .ref_clk_in    (ref_clk_in),
        .reset_in      (reset_in),
        .run_in        (busy_r | hold_r),
        .restart_in    (shift_wr),
        .src_sel_in    (sync_serial_control_r[`CCSP_CTRL_SRC_HI:`CCSP_CTRL_SRC_LO]),
        .divisor_in    (sync_serial_rate_divisor_r),
        .half_tick_out (half_tick)
    );

    // leading edge leaves the idle level and shifts out, trailing edge samples
    assign lead_int  = busy_r & half_tick & (clk_r == idle_lvl);
    assign trail_int = busy_r & half_tick & (clk_r != idle_lvl);
    // external edges shift whenever they arrive, busy or not
    assign lead_ext  = (pin_prev_r == idle_lvl) & (sync_clock_pin_in != idle_lvl);
    assign trail_ext = (pin_prev_r != idle_lvl) & (sync_clock_pin_in == idle_lvl);
    assign lead  = serial_enable & (internal_clock_select ? lead_int : lead_ext);
    assign trail = serial_enable & (internal_clock_select ? trail_int : trail_ext);

    // counter wraps, so a ninth external clock pulse starts a new word
    assign last_bit = (bit_cnt_r == `CCSP_BIT_LAST);
    assign done_ev  = trail & last_bit;

    // bit order: 0 sends bit 0 first, 1 sends bit 7 first
    assign next_bit  = bit_order_select ? sync_serial_shift_register_r[7] :
                                          sync_serial_shift_register_r[0];
    assign first_bit = bit_order_select ? avs_writedata_in[7] : avs_writedata_in[0];
    // each bit takes a neighbour, the bit at the far end takes the data pin
    genvar gi;
    generate
        for (gi = `CCSP_BIT_FIRST; gi <= `CCSP_BIT_LAST; gi = gi + 1) begin : g_shift
            if (gi == `CCSP_BIT_FIRST) begin : g_first
                assign shifted[gi] = bit_order_select ? sync_data_in_pin_in :
                                                        sync_serial_shift_register_r[gi+1];
            end else if (gi == `CCSP_BIT_LAST) begin : g_last
                assign shifted[gi] = bit_order_select ? sync_serial_shift_register_r[gi-1] :
                                                        sync_data_in_pin_in;
            end else begin : g_mid
                assign shifted[gi] = bit_order_select ? sync_serial_shift_register_r[gi-1] :
                                                        sync_serial_shift_register_r[gi+1];
            end
        end
    endgenerate

    // configuration registers
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync_serial_control_r      <= `CCSP_CTRL_RESET;
            sync_serial_rate_divisor_r <= `CCSP_RATE_RESET;
            mask_r                     <= 1'b0;
            gpio_r                     <= `CCSP_GPIO_RESET;
        end else if (avs_write_in) begin
            case (avs_address_in)
                `CCSP_ADDR_CTRL: begin
                    sync_serial_control_r <= avs_writedata_in[6:0];
                end
                `CCSP_ADDR_RATE: begin
                    sync_serial_rate_divisor_r <= avs_writedata_in[7:0];
                end
                `CCSP_ADDR_MASK: begin
                    mask_r <= avs_writedata_in[`CCSP_STAT_DONE];
                end
                `CCSP_ADDR_GPIO: begin
                    gpio_r <= avs_writedata_in[3:0];
                end
                default: begin
                end
            endcase
        end
    end

    // external clock pin history for edge detection, pin is synchronous
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_prev_r <= 1'b1;
        end else begin
            pin_prev_r <= sync_clock_pin_in;
        end
    end

    // shifter and transfer sequencing
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync_serial_shift_register_r <= 8'h00;
            busy_r                       <= 1'b0;
            bit_cnt_r                    <= `CCSP_BIT_FIRST;
            clk_r                        <= 1'b1;
            out_bit_r                    <= 1'b0;
            hold_r                       <= 1'b0;
            fresh_r                      <= 1'b0;
        end else if (shift_wr) begin
            // no buffer: a write mid-transfer restarts with the new word
            sync_serial_shift_register_r <= avs_writedata_in[7:0];
            busy_r                       <= 1'b1;
            bit_cnt_r                    <= `CCSP_BIT_FIRST;
            clk_r                        <= idle_lvl;
            out_bit_r                    <= first_bit;
            hold_r                       <= 1'b0;
            fresh_r                      <= 1'b1;
        end else begin
            if (!busy_r) begin
                clk_r <= idle_lvl;
            end else if (internal_clock_select && half_tick) begin
                clk_r <= ~clk_r;
            end
            if (lead) begin
                fresh_r <= 1'b0;
                if (bit_cnt_r != `CCSP_BIT_FIRST) begin
                    out_bit_r <= next_bit;
                end
            end
            if (hold_r && half_tick) begin
                hold_r <= 1'b0;
            end
            if (trail) begin
                sync_serial_shift_register_r <= shifted;
                bit_cnt_r                    <= bit_cnt_r + 3'h1;
                if (last_bit) begin
                    // received word stays until the next write or the next external sample edge
                    busy_r <= 1'b0;
                    hold_r <= internal_clock_select;
                end
            end
        end
    end

    // sticky done flag: a set in the clearing read cycle wins
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            done_r <= 1'b0;
        end else if (done_ev) begin
            done_r <= 1'b1;
        end else if (status_rd) begin
            // read clears, so software sees each event once
            done_r <= 1'b0;
        end
    end

    assign irq_out = done_r & mask_r;

    // read mux and registered read data
    always @* begin
        rd_mux = 32'h0000_0000;
        case (avs_address_in)
            `CCSP_ADDR_CTRL:   rd_mux[6:0] = sync_serial_control_r;
            `CCSP_ADDR_RATE:   rd_mux[7:0] = sync_serial_rate_divisor_r;
            `CCSP_ADDR_SHIFT:  rd_mux[7:0] = sync_serial_shift_register_r;
            `CCSP_ADDR_STATUS: begin
                rd_mux[`CCSP_STAT_DONE] = done_r;
                rd_mux[`CCSP_STAT_BUSY] = busy_r;
            end
            `CCSP_ADDR_MASK:   rd_mux[`CCSP_STAT_DONE] = mask_r;
            `CCSP_ADDR_GPIO: begin
                rd_mux[3:0]                 = gpio_r;
                rd_mux[`CCSP_GPIO_CLK_PIN]  = sync_clock_pin_in;
                rd_mux[`CCSP_GPIO_DATA_PIN] = sync_data_in_pin_in;
            end
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    // one wait state buys read data straight from a flop
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_ack_r   <= 1'b0;
            readdata_r <= 32'h0000_0000;
        end else begin
            rd_ack_r <= avs_read_in & ~rd_ack_r;
            if (avs_read_in && !rd_ack_r) begin
                readdata_r <= rd_mux;
            end
        end
    end

    // pin functions: general port when serial is off, else clock in or out
    always @* begin
        clk_pin_mux   = gpio_r[`CCSP_GPIO_CLK_VAL];
        clk_oe_n_mux  = ~gpio_r[`CCSP_GPIO_CLK_DIR];
        data_pin_mux  = gpio_r[`CCSP_GPIO_DATA_VAL];
        data_oe_n_mux = ~gpio_r[`CCSP_GPIO_DATA_DIR];
        if (serial_enable) begin
            if (internal_clock_select) begin
                // clock parks at its idle level outside a transfer
                clk_pin_mux   = busy_r ? clk_r : idle_lvl;
                clk_oe_n_mux  = 1'b0;
                data_pin_mux  = out_bit_r;
                // data floats between transfers, after the hold
                data_oe_n_mux = ~((busy_r & ~fresh_r) | hold_r);
            end else begin
                // clock pin is an input, data rests at the chosen level
                clk_pin_mux   = 1'b0;
                clk_oe_n_mux  = 1'b1;
                data_pin_mux  = busy_r ? out_bit_r : idle_output_level_select;
                data_oe_n_mux = 1'b0;
            end
        end
    end

    assign sync_clock_pin_out         = clk_pin_mux;
    assign sync_clock_pin_oe_n_out    = clk_oe_n_mux;
    assign sync_data_out_pin_out      = data_pin_mux;
    assign sync_data_out_pin_oe_n_out = data_oe_n_mux;

endmodule

//--- src/ccsp_regs.vh
// register map, field positions and constants of the clock synchronous serial port
`ifndef CCSP_REGS_VH
`define CCSP_REGS_VH

`define CCSP_ADDR_W          3
`define CCSP_ADDR_CTRL       3'h0
`define CCSP_ADDR_RATE       3'h1
`define CCSP_ADDR_SHIFT      3'h2
`define CCSP_ADDR_STATUS     3'h3
`define CCSP_ADDR_MASK       3'h4
`define CCSP_ADDR_GPIO       3'h5

`define CCSP_CTRL_POL        0
`define CCSP_CTRL_ORDER      1
`define CCSP_CTRL_INTCLK     2
`define CCSP_CTRL_IDLE       3
`define CCSP_CTRL_SRC_LO     4
`define CCSP_CTRL_SRC_HI     5
`define CCSP_CTRL_SER_EN     6
`define CCSP_CTRL_RESET      7'h00

`define CCSP_RATE_RESET      8'h00
`define CCSP_SRC_DIV1        2'h0
`define CCSP_SRC_DIV8        2'h1
`define CCSP_SRC_DIV32       2'h2
`define CCSP_PRE_DIV8_MASK   5'h07
`define CCSP_PRE_DIV32_MASK  5'h1f

`define CCSP_BIT_LAST        3'h7
`define CCSP_BIT_FIRST       3'h0

`define CCSP_STAT_DONE       0
`define CCSP_STAT_BUSY       1

`define CCSP_GPIO_CLK_VAL    0
`define CCSP_GPIO_CLK_DIR    1
`define CCSP_GPIO_DATA_VAL   2
`define CCSP_GPIO_DATA_DIR   3
`define CCSP_GPIO_CLK_PIN    4
`define CCSP_GPIO_DATA_PIN   5
`define CCSP_GPIO_RESET      4'h0

`endif

//--- src/ccsp_rate_gen.v
// prescaler and divisor counter producing transfer clock half-period ticks
`timescale 1ns/1ps
`include "ccsp_regs.vh"

module ccsp_rate_gen (
    // clock and reset
    input  wire       ref_clk_in,
    input  wire       reset_in,
    // control
    input  wire       run_in,
    input  wire       restart_in,
    input  wire [1:0] src_sel_in,
    input  wire [7:0] divisor_in,
    // tick
    output reg        half_tick_out
);

    reg  [4:0] pre_r;
    reg  [7:0] div_cnt_r;
    reg        src_tick;

    always @* begin
        case (src_sel_in)
            `CCSP_SRC_DIV1: src_tick = 1'b1;
            `CCSP_SRC_DIV8: src_tick = ((pre_r & `CCSP_PRE_DIV8_MASK) == `CCSP_PRE_DIV8_MASK);
            default:        src_tick = (pre_r == `CCSP_PRE_DIV32_MASK);
        endcase
    end

    // free running prescaler, so a selected source keeps its own phase
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pre_r <= 5'h00;
        end else begin
            pre_r <= pre_r + 5'h01;
        end
    end

    // half period is n+1 source ticks, full period 2(n+1)
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            div_cnt_r     <= 8'h00;
            half_tick_out <= 1'b0;
        end else if (restart_in || !run_in) begin
            div_cnt_r     <= 8'h00;
            half_tick_out <= 1'b0;
        end else if (src_tick) begin
            if (div_cnt_r == divisor_in) begin
                div_cnt_r     <= 8'h00;
                half_tick_out <= 1'b1;
            end else begin
                div_cnt_r     <= div_cnt_r + 8'h01;
                half_tick_out <= 1'b0;
            end
        end else begin
            half_tick_out <= 1'b0;
        end
    end

endmodule

//--- tb/ccsp_properties.sv
// port checker for ccsp_top
`timescale 1ns/1ps
module ccsp_checker (
    // clock and reset
    input wire        ref_clk_in,
    input wire        reset_in,
    // register bus
    input wire [2:0]  avs_address_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [31:0] avs_readdata_out,
    input wire        avs_waitrequest_out,
    // interrupt and pins
    input wire        irq_out,
    input wire        sync_clock_pin_in,
    input wire        sync_clock_pin_out,
    input wire        sync_clock_pin_oe_n_out,
    input wire        sync_data_out_pin_out,
    input wire        sync_data_out_pin_oe_n_out,
    input wire        sync_data_in_pin_in
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    // shadows of writes; a cycle of settling after each control change
    reg  [6:0] ctl_r;
    reg  [6:0] ctl_q_r;
    reg        msk_r;
    reg        ck_q_r;
    reg  [4:0] edg_r;
    wire       chg = sync_clock_pin_out != ck_q_r;
    wire       wsh = avs_write_in && avs_address_in == 3'h2;
    wire       intm = ctl_r[6] && ctl_r[2] && ctl_r == ctl_q_r;
    wire       extm = ctl_r[6] && !ctl_r[2] && ctl_r == ctl_q_r;
    wire       last = intm && edg_r == 5'h0f && chg && !wsh;
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctl_r <= 7'h00;
            ctl_q_r <= 7'h00;
            msk_r <= 1'b0;
            ck_q_r <= 1'b0;
            edg_r <= 5'h00;
        end else begin
            ctl_q_r <= ctl_r;
            ck_q_r <= sync_clock_pin_out;
            if (avs_write_in && avs_address_in == 3'h0)
                ctl_r <= avs_writedata_in[6:0];
            if (avs_write_in && avs_address_in == 3'h4)
                msk_r <= avs_writedata_in[0];
            if (wsh)
                edg_r <= 5'h00;
            else if (intm && chg && edg_r != 5'h1f)
                edg_r <= edg_r + 5'h01;
        end
    end
    write_no_wait_a: assert property (avs_write_in |-> !avs_waitrequest_out) else $error("write stalled");
    read_one_wait_a: assert property (avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("read not answered");
    unmapped_zero_a: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in > 3'h5
        |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
    pulse_limit_a: assert property (edg_r <= 5'h10) else $error("over eight pulses");
    clock_park_a: assert property (intm && edg_r == 5'h10 |-> !sync_clock_pin_oe_n_out &&
        sync_clock_pin_out == !ctl_r[0]) else $error("clock not parked");
    done_irq_a: assert property (last && msk_r |-> ##[1:3] irq_out) else $error("no done irq");
    hold_bit_a: assert property (last |-> !sync_data_out_pin_oe_n_out) else $error("data dropped");
    write_float_a: assert property (intm && wsh |-> ##2 (sync_data_out_pin_oe_n_out ||
        edg_r != 5'h00 || chg)) else $error("data not floated");
    ext_clock_in_a: assert property (extm |-> sync_clock_pin_oe_n_out) else $error("clock driven");
    ext_data_on_a: assert property (extm |-> !sync_data_out_pin_oe_n_out) else $error("data floats");
    mask_off_a: assert property (!msk_r |-> !irq_out) else $error("masked irq seen");
    cover property (last);
    cover property (extm && wsh);
    cover property (irq_out && msk_r);
endmodule
bind ccsp_top ccsp_checker u_chk (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
    .sync_clock_pin_in(sync_clock_pin_in), .sync_clock_pin_out(sync_clock_pin_out),
    .sync_clock_pin_oe_n_out(sync_clock_pin_oe_n_out), .sync_data_out_pin_out(sync_data_out_pin_out),
    .sync_data_out_pin_oe_n_out(sync_data_out_pin_oe_n_out), .sync_data_in_pin_in(sync_data_in_pin_in));

//--- tb/ccsp_partner.sv
// far-side serial device, follows or makes the transfer clock
`timescale 1ns/1ps
module ccsp_partner (
    // clock and setup
    input  wire       ref_clk_in,
    input  wire       pol_in,
    input  wire       msb_in,
    input  wire       gen_in,
    input  wire       start_in,
    input  wire [7:0] tx_in,
    // serial lines
    input  wire       clk_line_in,
    input  wire       dout_line_in,
    output reg        clk_drv_out = 1'b1,
    output reg        din_out = 1'b0,
    // observations
    output reg  [7:0] rx_out = 8'h00,
    output reg  [4:0] edges_out = 5'h00,
    output reg  [7:0] half_out = 8'h00
);
    reg  [7:0] gap_r = 8'h00;
    reg  [4:0] left_r = 5'h00;
    reg  [2:0] tick_r = 3'h0;
    reg        ck_q_r = 1'b1;
    wire       edg = clk_line_in != ck_q_r;
    wire [2:0] bit_w = msb_in ? ~edges_out[3:1] : edges_out[3:1];
    always @(posedge ref_clk_in) begin
        ck_q_r <= clk_line_in;
        gap_r <= edg ? 8'h01 : gap_r + 8'h01;
        tick_r <= start_in ? 3'h0 : tick_r + 3'h1;
        if (edg) begin
            half_out <= gap_r;
            edges_out <= edges_out + {4'h0, edges_out != 5'h1f};
        end
        // outside a frame the line wanders, so a stale bit never passes
        if (edg && clk_line_in == pol_in)
            din_out <= tx_in[bit_w];
        else if (edg)
            rx_out[bit_w] <= dout_line_in;
        else if (edges_out == 5'h00 || edges_out > 5'h0f)
            din_out <= !din_out;
        if (left_r == 5'h00)
            clk_drv_out <= !pol_in;
        else if (tick_r == 3'h7) begin
            clk_drv_out <= !clk_drv_out;
            left_r <= left_r - 5'h01;
        end
        if (start_in) begin
            edges_out <= 5'h00;
            left_r <= gen_in ? 5'h10 : 5'h00;
        end
    end
endmodule

//--- tb/tb_clock_sync_serial_port.sv
// bench for ccsp_top with a far-side device model
`timescale 1ns/1ps
module tb_clock_sync_serial_port;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [2:0]  adr = 3'h0;
    reg         rd = 1'b0;
    reg         wr = 1'b0;
    reg  [31:0] wd = 32'h0;
    reg         pp = 1'b0;
    reg         pm = 1'b0;
    reg         pg = 1'b0;
    reg         ps = 1'b0;
    reg  [7:0]  ptx = 8'h00;
    wire [31:0] rdat;
    wire [7:0]  prx;
    wire [7:0]  phalf;
    wire [4:0]  pedg;
    wire        wreq, irq, cko, ckoe, dout, doe, pck, din;
    wire        ckl = ckoe ? pck : cko;
    wire        dl = doe ? din : dout;
    integer     err_total = 0;
    integer     n_checks = 0;
    reg  [31:0] rv;
    ccsp_top dut (
        .ref_clk_in(clk), .reset_in(rst), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .irq_out(irq),
        .sync_clock_pin_in(ckl), .sync_clock_pin_out(cko), .sync_clock_pin_oe_n_out(ckoe),
        .sync_data_out_pin_out(dout), .sync_data_out_pin_oe_n_out(doe), .sync_data_in_pin_in(din));
    ccsp_partner far (
        .ref_clk_in(clk), .pol_in(pp), .msb_in(pm), .gen_in(pg), .start_in(ps), .tx_in(ptx),
        .clk_line_in(ckl), .dout_line_in(dl), .clk_drv_out(pck), .din_out(din), .rx_out(prx),
        .edges_out(pedg), .half_out(phalf));
    initial forever #2 clk = !clk;
    task tally_and_finish;
        begin
            if (err_total == 0 && n_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task bus_wr(input [2:0] a, input [31:0] d);
        begin
            @(posedge clk);
            adr <= a;
            wd <= d;
            wr <= 1'b1;
            @(posedge clk);
            while (wreq) @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task bus_rd(input [2:0] a, input [31:0] d);
        begin
            @(posedge clk);
            adr <= a;
            rd <= 1'b1;
            @(posedge clk);
            while (wreq) @(posedge clk);
            rd <= 1'b0;
            chk(rdat, d);
        end
    endtask
    task wait_frame;
        integer k;
        begin
            k = 0;
            while (pedg !== 5'h10 && k < 9000) begin
                @(posedge clk);
                k = k + 1;
            end
            chk(pedg, 5'h10);
        end
    endtask
    task run_frame(input [7:0] tx);
        begin
            ps <= 1'b1;
            @(posedge clk);
            ps <= 1'b0;
            bus_wr(3'h2, {24'h0, tx});
            wait_frame;
        end
    endtask
    task t_regs;
        begin
            bus_rd(3'h0, 32'h0);
            bus_rd(3'h1, 32'h0);
            bus_wr(3'h5, 32'hb);
            @(posedge clk);
            chk({ckoe, cko, doe, dout}, 4'b0100);
            bus_wr(3'h7, 32'hff);
            bus_rd(3'h7, 32'h0);
            bus_rd(3'h6, 32'h0);
        end
    endtask
    task t_int(input pol, input msb, input [1:0] src, input [7:0] n, input msk, input [7:0] tx, input [7:0] rx);
        integer half;
        begin
            half = (n + 1) * (src == 2'h0 ? 1 : (src == 2'h1 ? 8 : 32));
            pp <= pol;
            pm <= msb;
            pg <= 1'b0;
            ptx <= rx;
            bus_wr(3'h1, {24'h0, n});
            bus_wr(3'h4, {31'h0, msk});
            bus_wr(3'h0, {25'h0, 1'b1, src, 2'b01, msb, pol});
            @(posedge clk);
            chk({ckoe, cko}, {1'b0, !pol});
            bus_rd(3'h0, {25'h0, 1'b1, src, 2'b01, msb, pol});
            bus_rd(3'h4, {31'h0, msk});
            run_frame(tx);
            chk(doe, 1'b0);
            repeat (3) @(posedge clk);
            chk(irq, msk);
            repeat (half) @(posedge clk);
            chk({doe, cko}, {1'b1, !pol});
            chk({prx, phalf}, {tx, half[7:0]});
            bus_rd(3'h2, {24'h0, rx});
            bus_rd(3'h3, 32'h1);
            chk(irq, 1'b0);
        end
    endtask
    task t_hold;
        begin
            bus_wr(3'h1, 32'h1f);
            bus_wr(3'h0, 32'h44);
            pp <= 1'b0;
            pm <= 1'b0;
            run_frame(8'h77);
            chk(doe, 1'b0);
            ps <= 1'b1;
            @(posedge clk);
            ps <= 1'b0;
            bus_wr(3'h2, 32'h18);
            @(posedge clk);
            chk(doe, 1'b1);
            wait_frame;
            chk(prx, 8'h18);
            bus_rd(3'h3, 32'h1);
        end
    endtask
    task t_ext(input pol, input idle, input [7:0] tx, input [7:0] rx);
        begin
            pp <= pol;
            pm <= 1'b0;
            pg <= 1'b1;
            ptx <= rx;
            bus_wr(3'h4, 32'h1);
            bus_wr(3'h0, {25'h0, 1'b1, 2'h0, idle, 2'b00, pol});
            @(posedge clk);
            chk({ckoe, doe, dout}, {2'b10, idle});
            run_frame(tx);
            repeat (8) @(posedge clk);
            chk({irq, prx, doe, dout}, {1'b1, tx, 1'b0, idle});
            bus_rd(3'h2, {24'h0, rx});
            bus_rd(3'h3, 32'h1);
        end
    endtask
    initial begin
        #100000;
        err_total = err_total + 1;
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_int(1'b0, 1'b0, 2'h0, 8'h03, 1'b1, 8'ha5, 8'h3c);
        t_int(1'b1, 1'b1, 2'h1, 8'h00, 1'b1, 8'h96, 8'hc3);
        t_int(1'b0, 1'b1, 2'h2, 8'h00, 1'b0, 8'h5a, 8'h81);
        t_hold;
        t_ext(1'b0, 1'b1, 8'h3c, 8'h69);
        t_ext(1'b1, 1'b0, 8'hd2, 8'h1e);
        tally_and_finish;
    end
endmodule
